// [rtl/coe_regs.svh]
// offsets, field positions, reset values and counts of the op executor
// What this block does
// - sleep op zeroes the watchdog counter and its prescaler
// - sleep op clears power_down_flag, sets timeout_flag, touches no other flag
// - reg_minus_acc_op writes register minus accumulator, sets three flags
// - literal_minus_acc_op writes literal minus accumulator to accumulator
// - reg_minus_acc_borrow_op also subtracts the inverted borrow bit
// - borrow set when accumulator plus inverted borrow-in not above operand; same on low nibble
// - destination bit 0 writes accumulator, 1 writes register 0 to 127
// - direction_load_op copies accumulator to port A, B, C on 5, 6, 7
// - literal_exclusive_or_op xors accumulator with literal, only Z changes
// - reg_exclusive_or_op xors accumulator with register, only Z changes
`ifndef COE_REGS_SVH
`define COE_REGS_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define COE_ADDR_W 8
`define COE_DATA_W 16
`define COE_FILE_TOP 8'h7f

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define COE_OFF_ACC 8'h80
`define COE_OFF_STATUS 8'h81
`define COE_OFF_CMD 8'h82
`define COE_OFF_DIR_A 8'h83
`define COE_OFF_DIR_B 8'h84
`define COE_OFF_DIR_C 8'h85
`define COE_OFF_WDOG 8'h86
`define COE_OFF_STATE 8'h87

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define COE_ST_C 0
`define COE_ST_HB 1
`define COE_ST_Z 2
`define COE_ST_PWRDN 3
`define COE_ST_TMOUT 4
`define COE_STATUS_RST 8'h18
`define COE_CMD_OP_HI 15
`define COE_CMD_OP_LO 12
`define COE_CMD_D 8
`define COE_DIR_SEL_A 8'h05
`define COE_DIR_SEL_B 8'h06
`define COE_DIR_SEL_C 8'h07
`define COE_DIR_RST 8'hff
`define COE_WDOG_RST 8'h00
`define COE_WDOG_PRESCALE 256

`endif

// [rtl/coe_pkg.sv]
// types shared by the op executor and its arithmetic unit
package coe_pkg;
  `include "coe_regs.svh"

  typedef logic [`COE_ADDR_W-1:0] coe_addr_t;
  typedef logic [`COE_DATA_W-1:0] coe_word_t;
  typedef logic [7:0] coe_byte_t;

  // command codes carried in the top nibble of a command write
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SLEEP = 4'h1,
    OP_REG_MINUS_ACC = 4'h2,
    OP_LIT_MINUS_ACC = 4'h3,
    OP_REG_MINUS_ACC_B = 4'h4,
    OP_NIBBLE_EXCHANGE = 4'h5,
    OP_DIRECTION_LOAD = 4'h6,
    OP_LIT_XOR = 4'h7,
    OP_REG_XOR = 4'h8
  } coe_op_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10
  } coe_state_t;
endpackage

// [rtl/coe_alu_if.sv]
// operand and result bundle between the executor and its arithmetic unit
`timescale 1ns/1ps
interface coe_alu_if;
  import coe_pkg::*;
  coe_op_t op;
  coe_byte_t acc;
  coe_byte_t opnd;
  logic cin;
  coe_byte_t res;
  logic c;
  logic hb;
  logic z;
  modport core (output op, acc, opnd, cin, input res, c, hb, z);
  modport alu (input op, acc, opnd, cin, output res, c, hb, z);
endinterface

// [rtl/coe_alu.sv]
// combinational arithmetic unit: subtract, exclusive-or, nibble swap
`timescale 1ns/1ps
module coe_alu (
  coe_alu_if.alu bus
);
  import coe_pkg::*;

  logic [8:0] diff;
  logic [4:0] half;

  // subtraction by adding the inverted accumulator plus carry-in
  assign diff = {1'b0, bus.opnd} + {1'b0, ~bus.acc} + {8'h00, bus.cin};
  assign half = {1'b0, bus.opnd[3:0]} + {1'b0, ~bus.acc[3:0]}
    + {4'h0, bus.cin};

  // result select per command
  always_comb begin
    bus.res = bus.opnd;
    bus.c = 1'b0;
    bus.hb = 1'b0;
    case (bus.op)
      OP_REG_MINUS_ACC, OP_LIT_MINUS_ACC, OP_REG_MINUS_ACC_B: begin
        bus.res = diff[7:0];
        bus.c = diff[8];
        bus.hb = half[4];
      end
      OP_LIT_XOR, OP_REG_XOR: begin
        bus.res = bus.acc ^ bus.opnd;
      end
      OP_NIBBLE_EXCHANGE: begin
        bus.res = {bus.opnd[3:0], bus.opnd[7:4]};
      end
      default: begin
        bus.res = bus.opnd;
      end
    endcase
  end

  // zero detect on the full 8-bit result
  assign bus.z = (bus.res == 8'h00);
endmodule

// [rtl/coe_exec.sv]
// op executor: register file, accumulator, status, directions, watchdog
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "coe_regs.svh"
module coe_exec #(
  parameter int WDOG_PRESCALE = `COE_WDOG_PRESCALE
) (
  input logic i_clk_sys,
  input logic i_rst,
  input coe_pkg::coe_addr_t i_addr,
  input coe_pkg::coe_word_t i_wr_data,
  input logic i_wr_stb,
  input logic i_rd_stb,
  output coe_pkg::coe_word_t o_rd_data,
  output coe_pkg::coe_byte_t o_acc,
  output coe_pkg::coe_byte_t o_status,
  output coe_pkg::coe_byte_t o_port_a_dir,
  output coe_pkg::coe_byte_t o_port_b_dir,
  output coe_pkg::coe_byte_t o_port_c_dir,
  output coe_pkg::coe_byte_t o_wdog_count,
  output logic o_sleep
);
  import coe_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  localparam int PRE_W = 16;
  localparam int FILE_N = 128;

  if (WDOG_PRESCALE < 2 || WDOG_PRESCALE > 65536) begin : g_chk
    $error("watchdog prescale must lie in 2..65536");
  end

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(WDOG_PRESCALE - 1);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  coe_byte_t file_reg [FILE_N];
  coe_byte_t acc_reg;
  coe_byte_t acc_next;
  coe_byte_t status_reg;
  coe_byte_t status_next;
  coe_byte_t dir_a_reg;
  coe_byte_t dir_a_next;
  coe_byte_t dir_b_reg;
  coe_byte_t dir_b_next;
  coe_byte_t dir_c_reg;
  coe_byte_t dir_c_next;
  coe_byte_t wdog_reg;
  coe_byte_t wdog_next;
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  coe_state_t state_reg;
  coe_state_t state_next;
  logic sleep_reg;
  coe_word_t rd_data_reg;
  coe_word_t rd_next;

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  wire logic cmd_go;
  wire coe_op_t cmd_op;
  wire logic cmd_d;
  wire coe_byte_t cmd_k;
  wire logic [6:0] f_idx;
  wire coe_byte_t f_val;

  // a command write other than sleep both wakes the core and runs at once
  assign cmd_go = i_wr_stb && (i_addr == `COE_OFF_CMD);
  assign cmd_op = coe_op_t'(i_wr_data[`COE_CMD_OP_HI:`COE_CMD_OP_LO]);
  assign cmd_d = i_wr_data[`COE_CMD_D];
  assign cmd_k = i_wr_data[7:0];
  assign f_idx = cmd_k[6:0];
  assign f_val = file_reg[f_idx];

  wire logic is_sleep;
  wire logic is_sub_f;
  wire logic is_sub_l;
  wire logic is_subb;
  wire logic is_swap;
  wire logic is_dir;
  wire logic is_xor_l;
  wire logic is_xor_f;

  assign is_sleep = cmd_go && (cmd_op == OP_SLEEP);
  assign is_sub_f = cmd_go && (cmd_op == OP_REG_MINUS_ACC);
  assign is_sub_l = cmd_go && (cmd_op == OP_LIT_MINUS_ACC);
  assign is_subb = cmd_go && (cmd_op == OP_REG_MINUS_ACC_B);
  assign is_swap = cmd_go && (cmd_op == OP_NIBBLE_EXCHANGE);
  assign is_dir = cmd_go && (cmd_op == OP_DIRECTION_LOAD);
  assign is_xor_l = cmd_go && (cmd_op == OP_LIT_XOR);
  assign is_xor_f = cmd_go && (cmd_op == OP_REG_XOR);

  // register-operand commands honour the destination bit
  wire logic reg_op;
  wire logic to_acc;
  wire logic to_file;
  wire logic upd_cdc;
  wire logic upd_z;

  assign reg_op = is_sub_f || is_subb || is_swap || is_xor_f;
  assign to_acc = is_sub_l || is_xor_l || (reg_op && !cmd_d);
  assign to_file = reg_op && cmd_d;
  assign upd_cdc = is_sub_f || is_sub_l || is_subb;
  assign upd_z = upd_cdc || is_xor_l || is_xor_f;

  // ----------------------------------------------------------------------
  // arithmetic unit
  // ----------------------------------------------------------------------
  coe_alu_if alu_if ();

  coe_alu u_alu (
    .bus(alu_if.alu)
  );

  // literal commands take the immediate, the rest the addressed register
  assign alu_if.op = cmd_op;
  assign alu_if.acc = acc_reg;
  assign alu_if.opnd = (is_sub_l || is_xor_l) ? cmd_k : f_val;
  // plain subtract carries in one; with borrow it carries in the flag
  assign alu_if.cin = is_subb ? status_reg[`COE_ST_C] : 1'b1;

  // ----------------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------------
  wire logic wr_acc;
  wire logic wr_status;
  wire logic wr_dir_a;
  wire logic wr_dir_b;
  wire logic wr_dir_c;
  wire coe_byte_t wr_byte;

  assign wr_acc = i_wr_stb && (i_addr == `COE_OFF_ACC);
  assign wr_status = i_wr_stb && (i_addr == `COE_OFF_STATUS);
  assign wr_dir_a = i_wr_stb && (i_addr == `COE_OFF_DIR_A);
  assign wr_dir_b = i_wr_stb && (i_addr == `COE_OFF_DIR_B);
  assign wr_dir_c = i_wr_stb && (i_addr == `COE_OFF_DIR_C);
  assign wr_byte = i_wr_data[7:0];

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  wire logic pre_tick;
  wire logic wdog_ovf;

  // the prescaler makes a one-cycle tick that advances the counter
  assign pre_tick = (pre_reg == PRE_LAST);
  // sleep wins over an overflow in the same cycle
  assign wdog_ovf = pre_tick && (wdog_reg == 8'hff) && !is_sleep;
  assign pre_next = is_sleep ? '0
    : (pre_tick ? '0 : pre_reg + PRE_W'(1));
  assign wdog_next = is_sleep ? `COE_WDOG_RST
    : (pre_tick ? wdog_reg + 8'h01 : wdog_reg);

  // ----------------------------------------------------------------------
  // accumulator, status and direction next values
  // ----------------------------------------------------------------------
  assign acc_next = to_acc ? alu_if.res : (wr_acc ? wr_byte : acc_reg);

  wire logic c_next;
  wire logic hb_next;
  wire logic z_next;
  wire logic pwrdn_next;
  wire logic tmout_next;

  // only subtracts move C and half borrow; sleep and swap leave them be
  assign c_next = upd_cdc ? alu_if.c
    : (wr_status ? wr_byte[`COE_ST_C] : status_reg[`COE_ST_C]);
  assign hb_next = upd_cdc ? alu_if.hb
    : (wr_status ? wr_byte[`COE_ST_HB] : status_reg[`COE_ST_HB]);
  assign z_next = upd_z ? alu_if.z
    : (wr_status ? wr_byte[`COE_ST_Z] : status_reg[`COE_ST_Z]);
  // the power-down and timeout flags are hardware owned, active low
  assign pwrdn_next = is_sleep ? 1'b0 : status_reg[`COE_ST_PWRDN];
  assign tmout_next = is_sleep ? 1'b1
    : (wdog_ovf ? 1'b0 : status_reg[`COE_ST_TMOUT]);
  assign status_next = {3'b000, tmout_next, pwrdn_next, z_next, hb_next,
    c_next};

  // direction loads copy the accumulator, flags untouched
  assign dir_a_next = (is_dir && cmd_k == `COE_DIR_SEL_A) ? acc_reg
    : (wr_dir_a ? wr_byte : dir_a_reg);
  assign dir_b_next = (is_dir && cmd_k == `COE_DIR_SEL_B) ? acc_reg
    : (wr_dir_b ? wr_byte : dir_b_reg);
  assign dir_c_next = (is_dir && cmd_k == `COE_DIR_SEL_C) ? acc_reg
    : (wr_dir_c ? wr_byte : dir_c_reg);

  // ----------------------------------------------------------------------
  // run and sleep states
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (is_sleep) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (cmd_go && !is_sleep) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  wire coe_word_t rd_mux;
  wire logic file_sel;

  assign file_sel = (i_addr <= `COE_FILE_TOP);
  // unmapped offsets and the command slot read as zero
  assign rd_mux = file_sel ? {8'h00, file_reg[i_addr[6:0]]}
    : (i_addr == `COE_OFF_ACC) ? {8'h00, acc_reg}
    : (i_addr == `COE_OFF_STATUS) ? {8'h00, status_reg}
    : (i_addr == `COE_OFF_DIR_A) ? {8'h00, dir_a_reg}
    : (i_addr == `COE_OFF_DIR_B) ? {8'h00, dir_b_reg}
    : (i_addr == `COE_OFF_DIR_C) ? {8'h00, dir_c_reg}
    : (i_addr == `COE_OFF_WDOG) ? {8'h00, wdog_reg}
    : (i_addr == `COE_OFF_STATE) ? {14'h0000, state_reg}
    : 16'h0000;
  // data stand for the one cycle after the strobe only
  assign rd_next = i_rd_stb ? rd_mux : 16'h0000;

  // ----------------------------------------------------------------------
  // register file, one flip-flop byte per entry
  // ----------------------------------------------------------------------
  for (genvar gi = 0; gi < FILE_N; gi++) begin : g_file
    localparam logic [6:0] IDX = 7'(gi);
    wire logic hit_bus;
    wire logic hit_exec;
    assign hit_bus = i_wr_stb && file_sel && (i_addr[6:0] == IDX);
    assign hit_exec = to_file && (f_idx == IDX);
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        file_reg[gi] <= 8'h00;
      end else if (hit_exec) begin
        file_reg[gi] <= alu_if.res;
      end else if (hit_bus) begin
        file_reg[gi] <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      acc_reg <= 8'h00;
      status_reg <= `COE_STATUS_RST;
      dir_a_reg <= `COE_DIR_RST;
      dir_b_reg <= `COE_DIR_RST;
      dir_c_reg <= `COE_DIR_RST;
    end else begin
      acc_reg <= acc_next;
      status_reg <= status_next;
      dir_a_reg <= dir_a_next;
      dir_b_reg <= dir_b_next;
      dir_c_reg <= dir_c_next;
    end
  end

  // watchdog, state and read data
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wdog_reg <= `COE_WDOG_RST;
      pre_reg <= '0;
      state_reg <= ST_RUN;
      sleep_reg <= 1'b0;
      rd_data_reg <= 16'h0000;
    end else begin
      wdog_reg <= wdog_next;
      pre_reg <= pre_next;
      state_reg <= state_next;
      sleep_reg <= (state_next == ST_SLEEP);
      rd_data_reg <= rd_next;
    end
  end

  // every output is a flip-flop
  assign o_rd_data = rd_data_reg;
  assign o_acc = acc_reg;
  assign o_status = status_reg;
  assign o_port_a_dir = dir_a_reg;
  assign o_port_b_dir = dir_b_reg;
  assign o_port_c_dir = dir_c_reg;
  assign o_wdog_count = wdog_reg;
  assign o_sleep = sleep_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_sleep_wdog_clear: assert property (
    is_sleep |=> (wdog_reg == `COE_WDOG_RST) && (pre_reg == '0))
    else $error("sleep did not clear watchdog");

  a_sleep_flag_set: assert property (
    is_sleep |=> !status_reg[`COE_ST_PWRDN] && status_reg[`COE_ST_TMOUT]
      && (status_reg[2:0] == $past(status_reg[2:0])))
    else $error("sleep flags wrong");

  a_sub_reg_result: assert property (
    is_sub_f && !cmd_d |=>
      acc_reg == 8'($past(f_val) - $past(acc_reg)))
    else $error("register subtract result wrong");

  a_sub_lit_result: assert property (
    is_sub_l |=> acc_reg == 8'($past(cmd_k) - $past(acc_reg)))
    else $error("literal subtract result wrong");

  a_subb_result: assert property (
    is_subb && !cmd_d |=> acc_reg == 8'($past(f_val) - $past(acc_reg)
      - {7'h00, !$past(status_reg[`COE_ST_C])}))
    else $error("subtract with borrow result wrong");

  a_borrow_compare: assert property (
    is_sub_f || is_sub_l |=>
      status_reg[`COE_ST_C] == ($past(acc_reg) <= $past(alu_if.opnd))
      && status_reg[`COE_ST_HB]
        == ($past(acc_reg[3:0]) <= $past(alu_if.opnd[3:0])))
    else $error("borrow flags wrong");

  a_dest_file_write: assert property (
    to_file |=> (acc_reg == $past(acc_reg))
      && (file_reg[$past(f_idx)] == $past(alu_if.res)))
    else $error("file destination wrong");

  a_dir_b_load: assert property (
    is_dir && cmd_k == `COE_DIR_SEL_B |=>
      (o_port_b_dir == $past(acc_reg))
      && (status_reg[3:0] == $past(status_reg[3:0])))
    else $error("direction load wrong");

  a_xor_lit_flags: assert property (
    is_xor_l |=> (acc_reg == $past(acc_reg ^ cmd_k))
      && (status_reg[1:0] == $past(status_reg[1:0])))
    else $error("literal xor wrong");

  a_xor_reg_result: assert property (
    is_xor_f && !cmd_d |=> acc_reg == $past(acc_reg ^ f_val))
    else $error("register xor wrong");

  a_swap_nibbles: assert property (
    is_swap && cmd_d |=>
      (file_reg[$past(f_idx)] == {$past(f_val[3:0]), $past(f_val[7:4])})
      && (status_reg[3:0] == $past(status_reg[3:0])))
    else $error("nibble swap wrong");

  a_zero_flag: assert property (
    upd_z |=> status_reg[`COE_ST_Z] == ($past(alu_if.res) == 8'h00))
    else $error("zero flag wrong");

  c_sleep_wake: cover property (is_sleep ##[1:8] cmd_go ##1 !o_sleep);
  c_subb_borrow: cover property (is_subb && !status_reg[`COE_ST_C]);
  c_dir_c_load: cover property (is_dir && cmd_k == `COE_DIR_SEL_C);
  c_xor_zero: cover property (is_xor_f && alu_if.z);
endmodule

// [dv/core_op_execute_subset_tb.sv]
// self-checking bench for the op executor: random and corner commands
`timescale 1ns/1ps
`include "coe_regs.svh"
module core_op_execute_subset_tb;
  import coe_pkg::*;
  localparam int PRESC = 4;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  coe_addr_t i_addr = '0;
  coe_word_t i_wr_data = '0;
  logic i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0;
  coe_word_t o_rd_data;
  coe_byte_t o_acc, o_status, o_port_a_dir, o_port_b_dir, o_port_c_dir;
  coe_byte_t o_wdog_count;
  logic o_sleep;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] m_acc;
  logic [2:0] m_cdz;
  logic [7:0] m_file [128];
  logic [7:0] m_dir [3];
  logic [15:0] rdv;
  logic [3:0] ops [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8};

  // short prescale keeps the watchdog wrap inside a short run
  coe_exec #(.WDOG_PRESCALE(PRESC)) dut_u (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .o_rd_data(o_rd_data), .o_acc(o_acc), .o_status(o_status),
    .o_port_a_dir(o_port_a_dir), .o_port_b_dir(o_port_b_dir),
    .o_port_c_dir(o_port_c_dir), .o_wdog_count(o_wdog_count),
    .o_sleep(o_sleep));

  // ----------------------------------------------------------------------
  // clock, reporting
  // ----------------------------------------------------------------------
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // bus master: every change lands right after a rising edge
  // ----------------------------------------------------------------------
  task automatic drive(input logic w, input logic r, input logic [7:0] a,
                       input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr_stb <= w;
    i_rd_stb <= r;
    i_addr <= a;
    i_wr_data <= d;
  endtask

  // strobe drops at the taking edge; #1 lets that edge's updates land
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    drive(1'b1, 1'b0, a, d);
    drive(1'b0, 1'b0, a, 16'h0000);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    drive(1'b0, 1'b1, a, 16'h0000);
    drive(1'b0, 1'b0, a, 16'h0000);
    #1;
    d = o_rd_data;
  endtask

  // ----------------------------------------------------------------------
  // reference: {no borrow, half no borrow, f - w - !cin}, flags by compare
  // ----------------------------------------------------------------------
  function automatic logic [9:0] sub_calc(input logic [7:0] f,
                                          input logic [7:0] w,
                                          input logic cin);
    logic [8:0] wb;
    logic [4:0] hb;
    wb = {1'b0, w} + 9'(!cin);
    hb = {1'b0, w[3:0]} + 5'(!cin);
    return {(wb <= {1'b0, f}), (hb <= {1'b0, f[3:0]}),
            8'(f - w - 8'(!cin))};
  endfunction

  task automatic model(input logic [3:0] op, input logic d,
                       input logic [7:0] kf);
    logic [9:0] r;
    logic [6:0] fi;
    fi = kf[6:0];
    r = '0;
    case (op)
      4'h2: r = sub_calc(m_file[fi], m_acc, 1'b1);
      4'h3: r = sub_calc(kf, m_acc, 1'b1);
      4'h4: r = sub_calc(m_file[fi], m_acc, m_cdz[0]);
      4'h5: r = {2'b00, m_file[fi][3:0], m_file[fi][7:4]};
      4'h7: r = {2'b00, m_acc ^ kf};
      default: r = {2'b00, m_acc ^ m_file[fi]};
    endcase
    if (op inside {4'h2, 4'h3, 4'h4}) begin
      m_cdz = {r[7:0] == 8'h00, r[8], r[9]};
    end else if (op != 4'h5) begin
      m_cdz[2] = (r[7:0] == 8'h00);
    end
    if (op == 4'h3 || op == 4'h7 || !d) begin
      m_acc = r[7:0];
    end else begin
      m_file[fi] = r[7:0];
    end
  endtask

  // preload operands, issue one command, compare all visible results
  task automatic run_op(input logic [3:0] op, input logic d,
                        input logic [7:0] kf, input logic [7:0] acc,
                        input logic [7:0] fv, input logic [2:0] cdz);
    wr(`COE_OFF_ACC, {8'h00, acc});
    wr({1'b0, kf[6:0]}, {8'h00, fv});
    wr(`COE_OFF_STATUS, {13'h0000, cdz});
    m_acc = acc;
    m_file[kf[6:0]] = fv;
    m_cdz = cdz;
    model(op, d, kf);
    wr(`COE_OFF_CMD, {op, 3'b000, d, kf});
    chk({8'h00, o_acc}, {8'h00, m_acc});
    chk({13'h0000, o_status[2:0]}, {13'h0000, m_cdz});
    rd({1'b0, kf[6:0]}, rdv);
    chk(rdv, {8'h00, m_file[kf[6:0]]});
  endtask

  initial begin
    #2_000_000;
    $display("[ERR] %0t run limit reached", $time);
    num_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    void'($urandom(75));
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    chk({8'h00, o_status}, 16'h0018);
    chk({8'h00, o_port_a_dir & o_port_b_dir & o_port_c_dir}, 16'h00ff);
    chk({o_acc, o_wdog_count}, 16'h0000);
    chk({15'h0000, o_sleep}, 16'h0000);
    // a full watchdog wrap drops timeout_flag
    n = 0;
    while (o_status[`COE_ST_TMOUT] !== 1'b0 && n < 1200) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    chk({15'h0000, n >= 1016 && n <= 1030}, 16'h0001);
    // unmapped and write-only places read zero
    wr(8'h88, 16'hffff);
    rd(8'h88, rdv);
    chk(rdv, 16'h0000);
    rd(`COE_OFF_CMD, rdv);
    chk(rdv, 16'h0000);
    // hand-picked borders: equal operands, f=127, k=255, borrow in
    run_op(4'h2, 1'b0, 8'h10, 8'h33, 8'h33, 3'b000);
    run_op(4'h2, 1'b1, 8'h7f, 8'h34, 8'h33, 3'b111);
    run_op(4'h2, 1'b0, 8'h12, 8'h0f, 8'h10, 3'b000);
    run_op(4'h3, 1'b0, 8'hff, 8'h01, 8'h00, 3'b000);
    run_op(4'h3, 1'b1, 8'h00, 8'h01, 8'h00, 3'b111);
    run_op(4'h4, 1'b1, 8'h00, 8'h05, 8'h05, 3'b000);
    run_op(4'h4, 1'b0, 8'h20, 8'h05, 8'h06, 3'b001);
    run_op(4'h5, 1'b1, 8'h05, 8'h00, 8'ha5, 3'b101);
    run_op(4'h7, 1'b0, 8'h5a, 8'h5a, 8'h00, 3'b011);
    run_op(4'h8, 1'b1, 8'h91, 8'hc3, 8'hc3, 3'b000);
    repeat (80) begin
      run_op(ops[$urandom % 6], 1'($urandom), 8'($urandom), 8'($urandom),
             8'($urandom), 3'($urandom));
    end
    // direction loads: 5, 6, 7 hit a port; 4 and 8 hit nothing
    m_dir = '{8'hff, 8'hff, 8'hff};
    for (int k = 4; k <= 8; k++) begin
      m_acc = 8'($urandom);
      wr(`COE_OFF_ACC, {8'h00, m_acc});
      wr(`COE_OFF_CMD, {8'h60, 8'(k)});
      if (k >= 5 && k <= 7) begin
        m_dir[k-5] = m_acc;
      end
      chk({o_port_a_dir, o_port_b_dir}, {m_dir[0], m_dir[1]});
      chk({o_port_c_dir, o_acc}, {m_dir[2], m_acc});
      chk({13'h0000, o_status[2:0]}, {13'h0000, m_cdz});
    end
    // codes outside the list leave accumulator, flags and file alone
    wr(`COE_OFF_CMD, 16'h91ff);
    rd(8'h7f, rdv);
    chk({o_acc, 5'b00000, o_status[2:0]}, {m_acc, 5'b00000, m_cdz});
    chk(rdv, {8'h00, m_file[127]});
    // sleep while the watchdog is mid-count and timeout_flag is low
    wr(`COE_OFF_STATUS, 16'h0005);
    wr(`COE_OFF_CMD, 16'h1000);
    chk({15'h0000, o_sleep}, 16'h0001);
    chk({8'h00, o_wdog_count}, 16'h0000);
    chk({8'h00, o_status}, 16'h0015);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk({8'h00, o_wdog_count}, 16'h0000);
    rd(`COE_OFF_STATE, rdv);
    chk(rdv, 16'h0002);
    wr(`COE_OFF_CMD, 16'h1000);
    chk({15'h0000, o_sleep}, 16'h0001);
    // any command other than sleep wakes and still executes
    m_cdz = 3'b101;
    model(4'h7, 1'b0, 8'hff);
    wr(`COE_OFF_CMD, 16'h70ff);
    chk({15'h0000, o_sleep}, 16'h0000);
    chk({o_acc, 5'b00000, o_status[2:0]}, {m_acc, 5'b00000, m_cdz});
    rd(`COE_OFF_STATE, rdv);
    chk(rdv, 16'h0001);
    finish_test();
  end
endmodule
